// >>> fcsr_pkg.sv
/*
 * package for the flash command status and fault interrupt register block:
 * register offsets, field positions, reset values and carrier structs.
 * assumes a classic wishbone slave with 32-bit data, one register per word.
 */
package fcsr_pkg;

	// ****************************************
	// register map
	// ****************************************
	// printed offsets step by one, not by four: index, byte address = 4 * index
	localparam logic [15:0] FCSR_IDX_CONFIG = 16'h3024;
	localparam logic [15:0] FCSR_IDX_ERR_IRQ_EN = 16'h3025;
	localparam logic [15:0] FCSR_IDX_STATUS = 16'h3026;
	localparam logic [15:0] FCSR_IDX_ERR_STATUS = 16'h3027;
	localparam int FCSR_ADDR_W = 18;
	localparam logic [1:0] FCSR_WORD_LSB = 2'h0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int FCSR_CFG_DONE_IE = 7;
	localparam int FCSR_CFG_IGN_SF = 4;
	localparam int FCSR_CFG_FORCE_DF = 1;
	localparam int FCSR_CFG_FORCE_SF = 0;
	localparam int FCSR_EIE_DF = 1;
	localparam int FCSR_EIE_SF = 0;
	localparam int FCSR_ST_DONE = 7;
	localparam int FCSR_ST_ACC_ERR = 5;
	localparam int FCSR_ST_PROT_VIOL = 4;
	localparam int FCSR_ST_BUSY = 3;
	localparam int FCSR_ES_DF = 1;
	localparam int FCSR_ES_SF = 0;

	// writable masks; reserved bits stay zero
	localparam logic [7:0] FCSR_CFG_WMASK = 8'h93;
	localparam logic [7:0] FCSR_EIE_WMASK = 8'h03;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] FCSR_CFG_RST = 8'h00;
	localparam logic [7:0] FCSR_EIE_RST = 8'h00;
	localparam logic [7:0] FCSR_ZERO8 = 8'h00;
	localparam logic [31:0] FCSR_ZERO32 = 32'h0000_0000;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic array_read;
		logic real_single;
		logic real_double;
	} fcsr_read_evt_t;

	typedef struct packed {
		logic done;
		logic seq_violation;
		logic illegal_cmd;
		logic protect_hit;
	} fcsr_cmd_evt_t;

endpackage

// >>> fcsr_top.sv
/*
 * flash command status and fault interrupt register block, wishbone slave.
 * assumes the command engine and array read path run on clk_i and give
 * one-cycle event pulses; ack comes one cycle after a request is seen.
 */
`timescale 1ns/1ps

// Functional notes
// - config bit 7 enables command-complete interrupt while done flag set
// - reserved config, error-enable and status bits read zero, ignore writes
// - config bit 4 suppresses single-bit fault reporting and its interrupt
// - with force-double clear, double flag set only on real double fault
// - force-double set: every array read sets double flag, interrupt if enabled
// - force-double bit cleared only by software writing zero
// - force-single set: every array read sets single flag unless config bit 4 set; else real faults only
// - force-single bit cleared only by software writing zero
// - error-enable bit 1 enables double-bit fault interrupt
// - error-enable bit 0 enables single-bit fault interrupt
// - status bit 7 idle flag; writing one clears it, launches a command
// - status bit 5 access error set on sequence violation or illegal command
// - while access error set, writing one to done flag neither clears nor launches
// - access error cleared by writing one; writing zero has no effect
// - protection flag set on protected hit, write-one clears, blocks launch
// - config register sits at its offset and resets to zero
module fcsr_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [fcsr_pkg::FCSR_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// engine and array read events
	input wire fcsr_pkg::fcsr_read_evt_t read_evt_i,
	input wire fcsr_pkg::fcsr_cmd_evt_t cmd_evt_i,
	// command launch and interrupt requests
	output logic launch_o,
	output logic cmd_done_irq_o,
	output logic fault_irq_o
);

	// ****************************************
	// state
	// ****************************************
	logic [7:0] config_reg;
	logic [7:0] error_irq_enable_reg;
	logic cmd_done_flag_reg;
	logic access_error_flag_reg;
	logic protect_violation_flag_reg;
	logic single_fault_flag_reg;
	logic double_fault_flag_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic launch_reg;
	logic done_irq_reg;
	logic fault_irq_reg;

	logic req;
	logic wr;
	logic [7:0] wbyte;
	logic launch_req;
	logic set_sf;
	logic set_df;
	logic rd_req;
	logic ack_next;
	logic force_df;
	logic force_sf;
	logic ign_sf;
	logic launch_ok;

	logic wr_config;
	logic wr_err_irq_en;
	logic wr_status;
	logic wr_err_status;
	logic set_done;
	logic set_acc_err;
	logic clr_acc_err;
	logic clr_prot;
	logic clr_sf;
	logic clr_df;

	logic [7:0] config_next;
	logic [7:0] error_irq_enable_next;
	logic [7:0] status_byte;
	logic [7:0] err_status_byte;
	logic [31:0] rdata_next;
	logic done_irq_next;
	logic fault_irq_next;

	// ****************************************
	// helpers
	// ****************************************
	// decode used by both the write and read paths
	function automatic logic hit(input logic [fcsr_pkg::FCSR_ADDR_W-1:0] a,
		input logic [15:0] idx);
		hit = (a == {idx, fcsr_pkg::FCSR_WORD_LSB});
	endfunction

	// new request only, so the held request is not taken twice
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign wbyte = 8'(wb_dat_i);
	assign rd_req = req && !wb_we_i;
	// ack is a plain echo of a new request, so it never stretches
	assign ack_next = req;

	// ****************************************
	// write strobes and flag terms
	// ****************************************
	// one strobe per register, so each flag process has one set and one clear term
	assign wr_config = wr && hit(wb_adr_i, fcsr_pkg::FCSR_IDX_CONFIG);
	assign wr_err_irq_en = wr && hit(wb_adr_i, fcsr_pkg::FCSR_IDX_ERR_IRQ_EN);
	assign wr_status = wr && hit(wb_adr_i, fcsr_pkg::FCSR_IDX_STATUS);
	assign wr_err_status = wr && hit(wb_adr_i, fcsr_pkg::FCSR_IDX_ERR_STATUS);

	// a sequence violation or illegal command ends the command as well as flagging it
	assign set_done = cmd_evt_i.done || cmd_evt_i.seq_violation || cmd_evt_i.illegal_cmd;
	assign set_acc_err = cmd_evt_i.seq_violation || cmd_evt_i.illegal_cmd;
	assign clr_acc_err = wr_status && wbyte[fcsr_pkg::FCSR_ST_ACC_ERR];
	assign clr_prot = wr_status && wbyte[fcsr_pkg::FCSR_ST_PROT_VIOL];
	assign clr_sf = wr_err_status && wbyte[fcsr_pkg::FCSR_ES_SF];
	assign clr_df = wr_err_status && wbyte[fcsr_pkg::FCSR_ES_DF];

	// blocked while the access error or protection flag is still pending
	assign launch_ok = cmd_done_flag_reg && !access_error_flag_reg
		&& !protect_violation_flag_reg;
	assign launch_req = wr_status && wbyte[fcsr_pkg::FCSR_ST_DONE] && launch_ok;

	// forced faults hit every array read (single ones only while ign_sf is clear) and do not depend on real faults
	assign force_df = config_reg[fcsr_pkg::FCSR_CFG_FORCE_DF];
	assign force_sf = config_reg[fcsr_pkg::FCSR_CFG_FORCE_SF];
	assign ign_sf = config_reg[fcsr_pkg::FCSR_CFG_IGN_SF];
	assign set_df = read_evt_i.array_read
		&& (read_evt_i.real_double || force_df);
	assign set_sf = read_evt_i.array_read && !ign_sf
		&& (read_evt_i.real_single || force_sf);

	// ****************************************
	// wishbone handshake
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	// ****************************************
	// register next values
	// ****************************************
	// reserved bits are masked on the way in, so the read path needs no mask
	always_comb begin
		config_next = config_reg;
		if (wr_config) begin
			config_next = wbyte & fcsr_pkg::FCSR_CFG_WMASK;
		end
	end

	always_comb begin
		error_irq_enable_next = error_irq_enable_reg;
		if (wr_err_irq_en) begin
			error_irq_enable_next = wbyte & fcsr_pkg::FCSR_EIE_WMASK;
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// force bits are only ever changed by software, never by the read path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_reg <= fcsr_pkg::FCSR_CFG_RST;
		end else begin
			config_reg <= config_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			error_irq_enable_reg <= fcsr_pkg::FCSR_EIE_RST;
		end else begin
			error_irq_enable_reg <= error_irq_enable_next;
		end
	end

	// ****************************************
	// command status flags
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_done_flag_reg <= 1'b1;
		end else if (set_done) begin
			cmd_done_flag_reg <= 1'b1;
		end else if (launch_req) begin
			cmd_done_flag_reg <= 1'b0;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			access_error_flag_reg <= 1'b0;
		end else if (set_acc_err) begin
			access_error_flag_reg <= 1'b1;
		end else if (clr_acc_err) begin
			access_error_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			protect_violation_flag_reg <= 1'b0;
		end else if (cmd_evt_i.protect_hit) begin
			protect_violation_flag_reg <= 1'b1;
		end else if (clr_prot) begin
			protect_violation_flag_reg <= 1'b0;
		end
	end

	// ****************************************
	// fault flags
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			single_fault_flag_reg <= 1'b0;
		end else if (set_sf) begin
			single_fault_flag_reg <= 1'b1;
		end else if (clr_sf) begin
			single_fault_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			double_fault_flag_reg <= 1'b0;
		end else if (set_df) begin
			double_fault_flag_reg <= 1'b1;
		end else if (clr_df) begin
			double_fault_flag_reg <= 1'b0;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// status words are assembled bit by bit from the flags
	always_comb begin
		status_byte = fcsr_pkg::FCSR_ZERO8;
		status_byte[fcsr_pkg::FCSR_ST_DONE] = cmd_done_flag_reg;
		status_byte[fcsr_pkg::FCSR_ST_ACC_ERR] = access_error_flag_reg;
		status_byte[fcsr_pkg::FCSR_ST_PROT_VIOL] = protect_violation_flag_reg;
		// busy is derived, not stored, so it can never disagree with done
		status_byte[fcsr_pkg::FCSR_ST_BUSY] = !cmd_done_flag_reg;
	end

	// flags clear only by a write of one, never by a read
	always_comb begin
		err_status_byte = fcsr_pkg::FCSR_ZERO8;
		err_status_byte[fcsr_pkg::FCSR_ES_DF] = double_fault_flag_reg;
		err_status_byte[fcsr_pkg::FCSR_ES_SF] = single_fault_flag_reg;
	end

	// ****************************************
	// read select
	// ****************************************
	// unmapped words read zero and are still acked
	always_comb begin
		rdata_next = fcsr_pkg::FCSR_ZERO32;
		if (hit(wb_adr_i, fcsr_pkg::FCSR_IDX_CONFIG)) begin
			rdata_next = 32'(config_reg);
		end else if (hit(wb_adr_i, fcsr_pkg::FCSR_IDX_ERR_IRQ_EN)) begin
			rdata_next = 32'(error_irq_enable_reg);
		end else if (hit(wb_adr_i, fcsr_pkg::FCSR_IDX_STATUS)) begin
			rdata_next = 32'(status_byte);
		end else if (hit(wb_adr_i, fcsr_pkg::FCSR_IDX_ERR_STATUS)) begin
			rdata_next = 32'(err_status_byte);
		end
	end

	// read data is held between reads, so a late look still sees it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= fcsr_pkg::FCSR_ZERO32;
		end else if (rd_req) begin
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// launch and interrupt requests
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			launch_reg <= 1'b0;
		end else begin
			launch_reg <= launch_req;
		end
	end

	// ****************************************
	// interrupt request terms
	// ****************************************
	// registered so both requests leave the block straight from a flip-flop
	assign done_irq_next = cmd_done_flag_reg
		&& config_reg[fcsr_pkg::FCSR_CFG_DONE_IE];
	assign fault_irq_next =
		(double_fault_flag_reg && error_irq_enable_reg[fcsr_pkg::FCSR_EIE_DF])
		|| (single_fault_flag_reg && error_irq_enable_reg[fcsr_pkg::FCSR_EIE_SF]);

	// levels, one cycle behind the flags; they drop once the flag clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_irq_reg <= 1'b0;
		end else begin
			done_irq_reg <= done_irq_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_irq_reg <= 1'b0;
		end else begin
			fault_irq_reg <= fault_irq_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign launch_o = launch_reg;
	assign cmd_done_irq_o = done_irq_reg;
	assign fault_irq_o = fault_irq_reg;

endmodule

// >>> fcsr_top_assertions.sv
/* checker for fcsr_top: bus answer, launch and interrupt timing.
 * assumes one clock, sync reset; bound from the testbench top. */
`timescale 1ns/1ps
module fcsr_chk (
	// clock
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [fcsr_pkg::FCSR_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// events and requests
	input wire fcsr_pkg::fcsr_read_evt_t read_evt_i,
	input wire fcsr_pkg::fcsr_cmd_evt_t cmd_evt_i,
	input wire logic launch_o,
	input wire logic cmd_done_irq_o,
	input wire logic fault_irq_o
);
	// ****
	// helpers
	// ****
	logic tk;
	logic wr;
	logic rd;
	logic [15:0] ix;
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = tk && wb_we_i && wb_sel_i[0];
	assign rd = wb_ack_o && !wb_we_i;
	assign ix = wb_adr_i[fcsr_pkg::FCSR_ADDR_W-1:2];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****
	// properties
	// ****
	AST_ACK_NEXT: assert property (tk |=> wb_ack_o)
		else $error("no ack one cycle after request");
	AST_RESV_ZERO: assert property (rd |-> wb_dat_o[31:8] == 24'h0
		&& (ix != fcsr_pkg::FCSR_IDX_CONFIG || (wb_dat_o[7:0] & ~fcsr_pkg::FCSR_CFG_WMASK) == 0)
		&& (ix != fcsr_pkg::FCSR_IDX_ERR_IRQ_EN || wb_dat_o[7:2] == 6'h0))
		else $error("reserved bits read nonzero");
	AST_STATUS_READ: assert property (rd && ix == fcsr_pkg::FCSR_IDX_STATUS
		|-> wb_dat_o[6] == 1'b0 && wb_dat_o[2:0] == 3'h0 && wb_dat_o[3] != wb_dat_o[7])
		else $error("status word malformed");
	AST_LAUNCH_CAUSE: assert property (launch_o
		|-> $past(wr && ix == fcsr_pkg::FCSR_IDX_STATUS && wb_dat_i[7]))
		else $error("launch without status write");
	AST_LAUNCH_PULSE: assert property (launch_o |=> !launch_o)
		else $error("launch longer than one cycle");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst_i
		|=> !wb_ack_o && !launch_o && !cmd_done_irq_o && !fault_irq_o && wb_dat_o == 0)
		else $error("outputs active after reset");
	// a reset edge just before would make the change look spontaneous
	AST_DONE_IRQ_CAUSE: assert property (!$past(rst_i) && $changed(cmd_done_irq_o)
		|-> $past(wr || (|cmd_evt_i), 2))
		else $error("done irq changed without cause");
	AST_FAULT_IRQ_CAUSE: assert property (!$past(rst_i) && $changed(fault_irq_o)
		|-> $past(wr || (|read_evt_i), 2))
		else $error("fault irq changed without cause");
	COV_LAUNCH: cover property (launch_o);
	COV_DONE_IRQ: cover property ($rose(cmd_done_irq_o));
	COV_FAULT_IRQ: cover property ($rose(fault_irq_o));
endmodule

// >>> test_fcsr_top.sv
/* self-checking bench for fcsr_top over classic wishbone.
 * assumes fcsr_pkg and fcsr_top compiled first; bench drives every input. */
`timescale 1ns/1ps
module test_fcsr_top;
	localparam logic [15:0] CF = fcsr_pkg::FCSR_IDX_CONFIG;
	localparam logic [15:0] EI = fcsr_pkg::FCSR_IDX_ERR_IRQ_EN;
	localparam logic [15:0] ST = fcsr_pkg::FCSR_IDX_STATUS;
	localparam logic [15:0] ES = fcsr_pkg::FCSR_IDX_ERR_STATUS;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, lnch, irq_d, irq_f, ls;
	logic [17:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] di = 0, dq, q;
	fcsr_pkg::fcsr_read_evt_t re = '0;
	fcsr_pkg::fcsr_cmd_evt_t ce = '0;
	int miscompares = 0, n_checks = 0;
	always #50 clk_i = ~clk_i;
	fcsr_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dq),
		.wb_ack_o(ack), .read_evt_i(re), .cmd_evt_i(ce), .launch_o(lnch),
		.cmd_done_irq_o(irq_d), .fault_irq_o(irq_f));
	// ****
	// bus and compare tasks
	// ****
	task chk(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task wb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, fcsr_pkg::FCSR_WORD_LSB};
		sel <= 4'hF;
		di <= {24'h0, d};
		// bounded wait; a missing ack shows up as a mismatch
		repeat (20) if (ack !== 1'b1) @(posedge clk_i);
		chk(32'h1, {31'h0, ack});
		q = dq;
		ls = lnch;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rc(input logic [15:0] i, input logic [31:0] e);
		wb(1'b0, i, 8'h00);
		chk(e, q);
	endtask
	task wl(input logic [7:0] d, input logic e);
		wb(1'b1, ST, d);
		chk({31'h0, e}, {31'h0, ls});
	endtask
	task ev(input logic [2:0] r, input logic [3:0] c);
		@(posedge clk_i);
		re <= r;
		ce <= c;
		@(posedge clk_i);
		re <= '0;
		ce <= '0;
		@(posedge clk_i);
	endtask
	task ck(input logic d, input logic f);
		@(negedge clk_i);
		chk({30'h0, d, f}, {30'h0, irq_d, irq_f});
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task t_reset;
		rc(CF, 32'h00);
		rc(EI, 32'h00);
		rc(ST, 32'h80);
		rc(16'h3030, 32'h00);
		wb(1'b1, CF, 8'hFF);
		rc(CF, 32'h93);
		wb(1'b1, EI, 8'hFF);
		rc(EI, 32'h03);
		wb(1'b1, EI, 8'h00);
	endtask
	task t_done;
		wb(1'b1, CF, 8'h80);
		ck(1'b1, 1'b0);
		wl(8'h80, 1'b1);
		rc(ST, 32'h08);
		ck(1'b0, 1'b0);
		wl(8'h80, 1'b0);
		ev(3'h0, 4'h8);
		rc(ST, 32'h80);
		ck(1'b1, 1'b0);
		wb(1'b1, CF, 8'h00);
		ck(1'b0, 1'b0);
	endtask
	task t_err;
		ev(3'h0, 4'h4);
		rc(ST, 32'hA0);
		wl(8'h80, 1'b0);
		wb(1'b1, ST, 8'h00);
		rc(ST, 32'hA0);
		wb(1'b1, ST, 8'h20);
		rc(ST, 32'h80);
		ev(3'h0, 4'h2);
		rc(ST, 32'hA0);
		wb(1'b1, ST, 8'h20);
		ev(3'h0, 4'h1);
		wl(8'h80, 1'b0);
		wb(1'b1, ST, 8'h10);
		rc(ST, 32'h80);
	endtask
	task t_fault;
		wb(1'b1, EI, 8'h03);
		ev(3'h4, 4'h0);
		rc(ES, 32'h00);
		ev(3'h5, 4'h0);
		ck(1'b0, 1'b1);
		rc(ES, 32'h02);
		wb(1'b1, ES, 8'h03);
		wb(1'b1, CF, 8'h02);
		ev(3'h4, 4'h0);
		rc(ES, 32'h02);
		ck(1'b0, 1'b1);
		rc(CF, 32'h02);
		wb(1'b1, CF, 8'h01);
		wb(1'b1, ES, 8'h03);
		ev(3'h4, 4'h0);
		rc(ES, 32'h01);
		ck(1'b0, 1'b1);
		rc(CF, 32'h01);
		wb(1'b1, CF, 8'h11);
		wb(1'b1, ES, 8'h03);
		ev(3'h6, 4'h0);
		ck(1'b0, 1'b0);
		rc(ES, 32'h00);
		wb(1'b1, CF, 8'h00);
		wb(1'b1, EI, 8'h02);
		ev(3'h6, 4'h0);
		ck(1'b0, 1'b0);
		wb(1'b1, EI, 8'h01);
		ck(1'b0, 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_done;
		t_err;
		t_fault;
		test_done;
	end
	// whole run is well under a thousand cycles
	initial begin
		#1000000;
		miscompares++;
		test_done;
	end
endmodule
bind fcsr_top fcsr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .read_evt_i(read_evt_i),
	.cmd_evt_i(cmd_evt_i), .launch_o(launch_o), .cmd_done_irq_o(cmd_done_irq_o),
	.fault_irq_o(fault_irq_o));
